// ---- include/rdist_ctl_pkg.sv ----
package rdist_ctl_pkg;
    localparam logic [15:0] ctlr_offset = 16'h0000;
    localparam logic [15:0] clear_offset = 16'h0048;
    localparam logic [15:0] frame_mask = 16'hFFFF;
    localparam logic [31:0] frame_bytes = 32'h0001_0000;
    localparam int uwp_bit = 31;
    localparam int g1s_bit = 26;
    localparam int g1ns_bit = 25;
    localparam int g0_bit = 24;
    localparam int rwp_bit = 3;
    localparam int ir_bit = 2;
    localparam int ces_bit = 1;
    localparam int en_bit = 0;
    localparam logic reset_val = 1'b0;

    typedef struct packed {
        logic req;
        logic write;
        logic nonsecure;
        logic wide;
        logic [31:0] addr;
        logic [63:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] identifier;
    } clear_cmd_t;

    typedef enum logic [2:0] {
        fetch_idle = 3'b001,
        fetch_busy = 3'b010,
        fetch_done = 3'b100
    } fetch_state_t;
endpackage : rdist_ctl_pkg

// ---- rtl/redistributor_control_lpi_clear.sv ----
`timescale 1ns/10ps
`default_nettype none
// Contract
// [RL1] clear write clears named interrupt pending
// [RL2] 64-bit register, upper half reads zero
// [RL3] 32-bit write zero-extended to 64
// [RL4] ignore clear: disabled, unimplemented, not pending
// [RL5] bit 31 shows upstream writes outstanding
// [RL6] bit 26 blocks group 1 secure selection
// [RL7] bit 26 zero in single-state or nonsecure
// [RL8] bit 25 blocks group 1 nonsecure selection
// [RL9] bit 24 blocks group 0; nonsecure raz
// [RL10] no capability: disables raz; reset zero
// [RL11] bit 3 shows propagation outstanding
// [RL12] bit 2 reports invalidate registers present
// [RL13] bit 1 reports enable clearable
// [RL14] enable low: drop doorbells and translations
// [RL15] enable reserved zero if unsupported; reset zero
// [RL16] enable rising fetches pending table
// [RL17] routing off: clear or keep enable, fixed
// [RL18] software waits for write-pending before reprogram
// [RL19] select only awake, undisabled, enabled group
// [RL20] disable change forces target reselection
// [RL21] clear register only with feature, else raz
// [RL22] control frame first, then private frame
// [RL23] write-pending rises next cycle, falls on ack
module redistributor_control_lpi_clear #(
    parameter int id_bits = 16,
    parameter bit feature_present = 1'b1,
    parameter bit clear_enable_capable = 1'b1,
    parameter bit invalidate_regs_present = 1'b1,
    parameter bit clear_on_routing_off = 1'b1
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire rdist_ctl_pkg::reg_req_t bus_req,
    output logic bus_ack,
    output logic [63:0] bus_rdata,
    input wire logic selection_disable_capable,
    input wire logic single_security_state,
    input wire logic nonsecure_affinity_routing,
    input wire logic physical_local_irq_capable,
    input wire logic wake_for_one_of_n,
    input wire logic pe_sleep_flag,
    input wire logic [2:0] group_enable,
    input wire logic upstream_busy,
    input wire logic propagate_ack,
    input wire logic [31:0] pending_query_id,
    input wire logic pending_query_hit,
    output logic [31:0] pending_query_addr,
    output var rdist_ctl_pkg::clear_cmd_t clear_cmd,
    output logic fetch_start,
    input wire logic fetch_complete,
    output logic fetch_active,
    output logic [2:0] selectable,
    output logic reselect,
    input wire logic doorbell_in,
    input wire logic translate_in,
    output logic doorbell_accept,
    output logic translate_accept
);
    import rdist_ctl_pkg::*;

    logic en_q, en_d;
    logic g1s_q, g1ns_q, g0_q;
    logic [2:0] dis_d;
    logic rwp_q, rwp_d;
    logic [63:0] rdata_q;
    clear_cmd_t clr_q;
    fetch_state_t fst_q, fst_d;
    logic reselect_q;
    logic g1s_rd, g1ns_rd, g0_rd;
    logic [2:0] dis_eff;
    logic [2:0] awake_mask;

    // read-as-zero gate shared by the three disable fields
    function automatic logic raz_gate(
        input logic ok,
        input logic value
    );
        logic result;
        result = 1'b0;
        if (ok) begin
            result = value;
        end
        return result;
    endfunction : raz_gate

    // identifiers above the implemented width name no interrupt
    function automatic logic id_in_range(
        input logic [31:0] id,
        input int width
    );
        logic result;
        result = 1'b1;
        if (width < 32) begin
            result = (id >> width) == 32'h0000_0000;
        end
        return result;
    endfunction : id_in_range

    // places one control field at its bit of the 32-bit word
    function automatic logic [31:0] field_at(
        input logic value,
        input int position
    );
        logic [31:0] result;
        result = 32'h0000_0000;
        result[position] = value;
        return result;
    endfunction : field_at

    // 32-bit words widen to 64 with a zero upper half
    function automatic logic [63:0] zero_extend(
        input logic [31:0] word
    );
        logic [63:0] result;
        result = {32'h0000_0000, word};
        return result;
    endfunction : zero_extend

    // decode within the 64KB control frame; private frame follows it
    wire [15:0] frame_off = bus_req.addr[15:0] & frame_mask; // [RL22]
    wire in_ctl_frame = bus_req.addr < frame_bytes; // [RL22]
    wire off_ctlr = frame_off == ctlr_offset;
    wire off_clear = frame_off == clear_offset;
    wire hit_ctlr = in_ctl_frame && off_ctlr;
    wire hit_clr = in_ctl_frame && off_clear && feature_present; // [RL21]
    wire rd_req = bus_req.req && !bus_req.write;
    wire wr = bus_req.req && bus_req.write;
    wire ctl_wr = wr && hit_ctlr;
    // narrow writes carry only the low word, upper word forced to zero
    wire [63:0] wdata64 = bus_req.wide ? bus_req.wdata
        : zero_extend(bus_req.wdata[31:0]); // [RL3]
    wire [31:0] clr_id = wdata64[31:0]; // [RL2]
    wire id_implemented = id_in_range(clr_id, id_bits); // [RL4]
    wire clr_fire = wr && hit_clr && en_q && id_implemented
        && pending_query_hit; // [RL1] [RL4]

    wire en_allowed = physical_local_irq_capable
        && nonsecure_affinity_routing; // [RL15]
    wire g1s_ok = selection_disable_capable && !single_security_state
        && !bus_req.nonsecure; // [RL7] [RL10]
    wire g1ns_ok = selection_disable_capable; // [RL10]
    wire g0_ok = selection_disable_capable
        && (single_security_state || !bus_req.nonsecure); // [RL9]

    assign dis_d[2] = (ctl_wr && g1s_ok) ? wdata64[g1s_bit] : g1s_q; // [RL6]
    assign dis_d[1] = (ctl_wr && g1ns_ok) ? wdata64[g1ns_bit] : g1ns_q;
    assign dis_d[0] = (ctl_wr && g0_ok) ? wdata64[g0_bit] : g0_q; // [RL9]
    wire dis_g1s_chg = dis_d[2] != g1s_q;
    wire dis_g1ns_chg = dis_d[1] != g1ns_q;
    wire dis_g0_chg = dis_d[0] != g0_q;
    wire dis_change = dis_g1s_chg || dis_g1ns_chg || dis_g0_chg; // [RL11]

    // enable may be cleared by software only when clearable
    wire en_wr_val = wdata64[en_bit];
    wire en_sw_clear = ctl_wr && !en_wr_val && clear_enable_capable;
    wire en_sw_set = ctl_wr && en_wr_val;
    wire en_route_off = !nonsecure_affinity_routing
        && clear_on_routing_off; // [RL17]
    always_comb begin
        en_d = en_q;
        if (en_sw_set) begin
            en_d = 1'b1;
        end else if (en_sw_clear) begin
            en_d = 1'b0;
        end
        if (en_route_off || !physical_local_irq_capable) begin
            en_d = 1'b0; // [RL15] [RL17]
        end
        if (!en_allowed && !en_q) begin
            en_d = 1'b0; // [RL15]
        end
    end
    wire en_fell = en_q && !en_d;
    wire en_rose = !en_q && en_d;

    // tracked writes raise the flag; only the ack lets it fall
    wire tracked = dis_change || en_fell; // [RL11] [RL23]
    always_comb begin
        rwp_d = rwp_q;
        if (tracked) begin
            rwp_d = 1'b1; // [RL23]
        end else if (propagate_ack) begin
            rwp_d = 1'b0; // [RL23]
        end
    end

    always_comb begin
        fst_d = fst_q;
        case (fst_q)
            fetch_idle: begin
                if (en_rose) begin
                    fst_d = fetch_busy; // [RL16]
                end
            end
            fetch_busy: begin
                if (fetch_complete) begin
                    fst_d = fetch_done;
                end
            end
            fetch_done: begin
                fst_d = fetch_idle;
            end
            default: begin
                fst_d = fetch_idle;
            end
        endcase
    end

    // read gating: fields without access read zero
    assign g1s_rd = raz_gate(g1s_ok, g1s_q); // [RL7]
    assign g1ns_rd = raz_gate(g1ns_ok, g1ns_q); // [RL10]
    assign g0_rd = raz_gate(g0_ok, g0_q); // [RL9]

    wire [31:0] uwp_field = field_at(upstream_busy, uwp_bit); // [RL5]
    wire [31:0] g1s_field = field_at(g1s_rd, g1s_bit); // [RL6]
    wire [31:0] g1ns_field = field_at(g1ns_rd, g1ns_bit); // [RL8]
    wire [31:0] g0_field = field_at(g0_rd, g0_bit); // [RL9]
    wire [31:0] rwp_field = field_at(rwp_q, rwp_bit); // [RL11]
    wire [31:0] ir_field = field_at(invalidate_regs_present, ir_bit); // [RL12]
    wire [31:0] ces_field = field_at(clear_enable_capable, ces_bit); // [RL13]
    wire [31:0] en_field = field_at(en_q, en_bit); // [RL15]
    wire [31:0] ctlr_val = uwp_field | g1s_field | g1ns_field | g0_field
        | rwp_field | ir_field | ces_field | en_field;

    // clear register is write-only, so reads see zero
    wire [63:0] rd_mux = hit_ctlr ? zero_extend(ctlr_val)
        : 64'h0000_0000_0000_0000; // [RL2] [RL21]

    // stored disables only count while the capability is present
    assign dis_eff[2] = g1s_q && selection_disable_capable
        && !single_security_state; // [RL6] [RL7]
    assign dis_eff[1] = g1ns_q && selection_disable_capable; // [RL8]
    assign dis_eff[0] = g0_q && selection_disable_capable; // [RL9]
    // chosen policy: a sleeping pe joins 1-of-n only when waking allowed
    assign awake_mask = {3{!pe_sleep_flag || wake_for_one_of_n}}; // [RL19]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_q <= reset_val; // [RL15]
        end else begin
            en_q <= en_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            g1s_q <= reset_val; // [RL10]
        end else begin
            g1s_q <= dis_d[2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            g1ns_q <= reset_val; // [RL10]
        end else begin
            g1ns_q <= dis_d[1];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            g0_q <= reset_val; // [RL10]
        end else begin
            g0_q <= dis_d[0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rwp_q <= reset_val;
        end else begin
            rwp_q <= rwp_d; // [RL23]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            fst_q <= fetch_idle;
        end else begin
            fst_q <= fst_d; // [RL16]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            reselect_q <= 1'b0;
        end else begin
            reselect_q <= dis_change; // [RL20]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 64'h0000_0000_0000_0000;
        end else if (rd_req) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clr_q.valid <= 1'b0;
        end else begin
            clr_q.valid <= clr_fire; // [RL1]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clr_q.identifier <= 32'h0000_0000;
        end else if (clr_fire) begin
            clr_q.identifier <= clr_id; // [RL1]
        end
    end

    wire sel_g1s = awake_mask[2] && !dis_eff[2] && group_enable[2]; // [RL6]
    wire sel_g1ns = awake_mask[1] && !dis_eff[1] && group_enable[1]; // [RL8]
    wire sel_g0 = awake_mask[0] && !dis_eff[0] && group_enable[0]; // [RL9]
    // with the enable low, doorbells and translations are dropped
    wire lpi_live = en_q;

    assign bus_ack = bus_req.req;
    assign bus_rdata = rdata_q;
    assign pending_query_addr = clr_id;
    assign clear_cmd = clr_q;
    assign fetch_start = (fst_q == fetch_idle) && en_rose; // [RL16]
    assign fetch_active = fst_q == fetch_busy;
    assign reselect = reselect_q; // [RL20]
    assign selectable = {sel_g1s, sel_g1ns, sel_g0}; // [RL19]
    assign doorbell_accept = doorbell_in && lpi_live; // [RL14]
    assign translate_accept = translate_in && lpi_live; // [RL14]
endmodule : redistributor_control_lpi_clear
`default_nettype wire

// ---- tb/rdist_ctl_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
module rdist_ctl_asserts #(
    parameter int id_bits = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire rdist_ctl_pkg::reg_req_t bus_req,
    input wire logic [63:0] bus_rdata,
    input wire logic upstream_busy,
    input wire logic selection_disable_capable,
    input wire logic pe_sleep_flag,
    input wire logic wake_for_one_of_n,
    input wire logic [2:0] selectable,
    input wire logic pending_query_hit,
    input wire rdist_ctl_pkg::clear_cmd_t clear_cmd
);
    import rdist_ctl_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic rd_any = bus_req.req && !bus_req.write;
    wire logic ctl_rd = rd_any && bus_req.addr == 32'h0;
    wire logic clr_wr = bus_req.req && bus_req.write &&
        bus_req.addr == {16'h0, clear_offset};
    AST_CLR_SRC: assert property (clear_cmd.valid |-> $past(clr_wr))
        else $error("clear without write");
    AST_CLR_ID: assert property (clear_cmd.valid |->
        clear_cmd.identifier == $past(bus_req.wdata[31:0])) else $error("id");
    AST_CLR_HIT: assert property (clear_cmd.valid |->
        $past(pending_query_hit)) else $error("clear of idle id");
    AST_CLR_RANGE: assert property (clear_cmd.valid |->
        ($past(bus_req.wdata[31:0]) >> id_bits) == 0) else $error("range");
    AST_UWP: assert property (ctl_rd |=>
        bus_rdata[uwp_bit] == $past(upstream_busy)) else $error("uwp");
    AST_UPPER: assert property (rd_any |=> bus_rdata[63:32] == 32'h0)
        else $error("upper half");
    AST_RAZ: assert property (ctl_rd && !selection_disable_capable |=>
        bus_rdata[g1s_bit:g0_bit] == 3'h0) else $error("disable bits");
    AST_SEL: assert property (pe_sleep_flag && !wake_for_one_of_n |->
        selectable == 3'h0) else $error("sleeping pe selected");
endmodule : rdist_ctl_asserts
bind redistributor_control_lpi_clear rdist_ctl_asserts #(.id_bits(id_bits))
    chk_u (
    .core_clk(core_clk),
    .rst(rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .upstream_busy(upstream_busy),
    .selection_disable_capable(selection_disable_capable),
    .pe_sleep_flag(pe_sleep_flag),
    .wake_for_one_of_n(wake_for_one_of_n),
    .selectable(selectable),
    .pending_query_hit(pending_query_hit),
    .clear_cmd(clear_cmd)
);
`default_nettype wire

// ---- tb/far_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module far_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire rdist_ctl_pkg::reg_req_t bus_req,
    input wire logic [31:0] pending_query_addr,
    input wire rdist_ctl_pkg::clear_cmd_t clear_cmd,
    input wire logic fetch_start,
    output logic pending_query_hit,
    output logic propagate_ack,
    output logic fetch_complete
);
    import rdist_ctl_pkg::*;
    logic [7:0] pend_q;
    logic [3:0] ack_q;
    logic [3:0] fin_q;
    // table indexed by low id bits only, so high ids alias
    assign pending_query_hit = pend_q[pending_query_addr[2:0]];
    assign propagate_ack = ack_q[3];
    assign fetch_complete = fin_q[3];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            {pend_q, ack_q, fin_q} <= {8'hA5, 8'h00};
        end else begin
            ack_q <= {ack_q[2:0], bus_req.req & bus_req.write};
            fin_q <= {fin_q[2:0], fetch_start};
            if (clear_cmd.valid) begin
                pend_q[clear_cmd.identifier[2:0]] <= 1'b0;
            end
        end
    end
endmodule : far_model
`default_nettype wire

// ---- tb/test_redistributor_control_lpi_clear.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_redistributor_control_lpi_clear;
    import rdist_ctl_pkg::*;
    logic core_clk = 0, rst = 1, upstream_busy = 0, pe_sleep_flag = 0;
    logic selection_disable_capable = 1, single_security_state = 0;
    logic nonsecure_affinity_routing = 1, physical_local_irq_capable = 1;
    logic wake_for_one_of_n = 0, doorbell_in = 1, translate_in = 1;
    logic [2:0] group_enable = 3'h7;
    logic [31:0] pending_query_id = 32'h0, last_id = 32'h0;
    reg_req_t bus_req = '0;
    wire logic bus_ack, pending_query_hit, propagate_ack, fetch_start;
    wire logic fetch_complete, fetch_active, reselect;
    wire logic doorbell_accept, translate_accept;
    wire logic [63:0] bus_rdata;
    wire logic [31:0] pending_query_addr;
    wire logic [2:0] selectable;
    wire clear_cmd_t clear_cmd;
    int fail_count = 0, n_tests = 0, cyc = 0, nclr = 0, nfetch = 0;
    int nresel = 0, nbusy = 0;
    redistributor_control_lpi_clear dut_u (.*);
    far_model far_u (.*);
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (clear_cmd.valid) nclr <= nclr + 1;
        if (clear_cmd.valid) last_id <= clear_cmd.identifier;
        if (fetch_start) nfetch <= nfetch + 1;
        if (reselect) nresel <= nresel + 1;
        if (fetch_active) nbusy <= nbusy + 1;
        if (cyc == 3000) print_verdict(1);
    end
    task automatic print_verdict(input int hung);
        fail_count = fail_count + hung;
        $display("mismatches %0d comparisons %0d", fail_count, n_tests);
        if (fail_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [63:0] exp, got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // one access; reads compare the word returned after the taking edge
    task automatic acc(input logic [31:0] a, input logic [63:0] d,
        input logic w, ns, input logic [63:0] exp);
        @(negedge core_clk);
        bus_req = '{1'b1, w, ns, 1'b0, a, d};
        @(negedge core_clk);
        bus_req.req = 1'b0;
        if (!w) chk("rdata", exp, bus_rdata);
    endtask : acc
    initial begin
        repeat (20) @(negedge core_clk);
        rst = 0;
        acc(0, 0, 0, 0, 64'h6);
        acc(0, 64'h0700_0000, 1, 0, 0);
        acc(0, 0, 0, 0, 64'h0700_000E);
        repeat (6) @(negedge core_clk);
        acc(0, 0, 0, 0, 64'h0700_0006);
        acc(0, 0, 1, 1, 0);
        repeat (6) @(negedge core_clk);
        acc(0, 0, 0, 1, 64'h6);
        acc(0, 0, 0, 0, 64'h0500_0006);
        chk("selectable", 64'h2, {61'h0, selectable});
        acc(0, 64'h0500_0001, 1, 0, 0);
        repeat (6) @(negedge core_clk);
        acc(0, 0, 0, 0, 64'h0500_0007);
        chk("fetch", 64'h1, 64'(nfetch));
        chk("busy cycles", 64'h4, 64'(nbusy));
        chk("accept", 64'h3, {62'h0, doorbell_accept, translate_accept});
        acc(32'h48, 64'hFFFF_FFFF_0000_0002, 1, 0, 0);
        acc(32'h48, 64'h1, 1, 0, 0);
        acc(32'h48, 64'h1_0005, 1, 0, 0);
        acc(32'h48, 0, 0, 0, 64'h0);
        chk("clear id", 64'h2, {32'h0, last_id});
        chk("clears", 64'h1, 64'(nclr));
        acc(0, 64'h0500_0000, 1, 0, 0);
        acc(0, 0, 0, 0, 64'h0500_000E);
        repeat (6) @(negedge core_clk);
        acc(0, 0, 0, 0, 64'h0500_0006);
        acc(32'h48, 64'h5, 1, 0, 0);
        chk("accept", 64'h0, {62'h0, doorbell_accept, translate_accept});
        upstream_busy = 1;
        selection_disable_capable = 0;
        pe_sleep_flag = 1;
        acc(0, 0, 0, 0, 64'h8000_0006);
        chk("clears", 64'h1, 64'(nclr));
        acc(32'h1_0000, 0, 0, 0, 64'h0);
        chk("selectable", 64'h0, {61'h0, selectable});
        wake_for_one_of_n = 1;
        @(negedge core_clk);
        chk("selectable", 64'h7, {61'h0, selectable});
        chk("reselects", 64'h2, 64'(nresel));
        print_verdict(0);
    end
endmodule : test_redistributor_control_lpi_clear
`default_nettype wire
